/* File: pkg/obf_defines.svh */
// constants for the output bit function block: codes, source indices,
// settings reset values. assumes inclusion by bare name from pkg/.
`ifndef OBF_DEFINES_SVH
`define OBF_DEFINES_SVH
// operation type codes
`define OBF_OP_DEFAULT 3'h0
`define OBF_OP_PRI_MANIP 3'h1
`define OBF_OP_SEC_MANIP 3'h2
`define OBF_OP_FN1 3'h3
`define OBF_OP_FN2 3'h4
`define OBF_OP_FN3 3'h5
`define OBF_OP_FN4 3'h6
// latch mode codes
`define OBF_LATCH_NONE 2'h0
`define OBF_LATCH_ON 2'h1
`define OBF_LATCH_OFF 2'h2
// settings reset values
`define OBF_SRC_POL_RST 4'h0
`define OBF_FINAL_POL_RST 1'h0
`define OBF_LATCH_RST 2'h0
`define OBF_OP_RST 3'h0
// source selection codes
`define OBF_SRC_OFF 6'h00
`define OBF_SRC_ON 6'h01
`define OBF_SRC_IEV1 6'h02
`define OBF_SRC_PRI_MANIP 6'h0E
`define OBF_SRC_SEC_MANIP 6'h0F
`define OBF_SRC_DI1 6'h12
`define OBF_SRC_ICON1 6'h1A
`define OBF_SRC_CDI1 6'h22
`define OBF_SRC_MANUAL 6'h26
`define OBF_SRC_READY 6'h27
`define OBF_SRC_AT 6'h29
`define OBF_SRC_RAMP 6'h2A
`define OBF_SRC_ALARM 6'h2C
`define OBF_SRC_PV_ALARM 6'h2D
`define OBF_SRC_MODE_KEY 6'h2F
`define OBF_SRC_EVT1 6'h30
`define OBF_SRC_CTL1 6'h31
// reset value of source A per output
`define OBF_CTL1_SEL_A_RST 6'h0E
`define OBF_CTL2_SEL_A_RST 6'h0F
`define OBF_EVT1_SEL_A_RST 6'h02
`define OBF_EVT2_SEL_A_RST 6'h03
`define OBF_EVT3_SEL_A_RST 6'h04
`endif

/* File: pkg/obf_pkg.sv */
// types of the output bit function block.
// assumes obf_defines.svh for the numeric codes.
package obf_pkg;
	typedef logic [5:0] obf_sel_t;
	typedef logic [2:0] obf_op_t;
	typedef logic [1:0] obf_latch_t;
	typedef logic [63:0] obf_src_vec_t;
endpackage

/* File: hdl/obf_channel.sv */
// one output: settings, source select, polarity, bit function, latch.
// assumes sources are synchronous to clk_sys_in.
`include "obf_defines.svh"
module obf_channel #(
	parameter obf_pkg::obf_sel_t SEL_A_RST = `OBF_SRC_OFF
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// settings write
	input wire logic cfg_load_in,
	input wire obf_pkg::obf_op_t op_type_in,
	input wire obf_pkg::obf_sel_t sel_a_in,
	input wire obf_pkg::obf_sel_t sel_b_in,
	input wire obf_pkg::obf_sel_t sel_c_in,
	input wire obf_pkg::obf_sel_t sel_d_in,
	input wire logic [3:0] src_polarity_in,
	input wire logic final_polarity_in,
	input wire obf_pkg::obf_latch_t latch_mode_in,
	// hardware fit
	input wire logic fitted_in,
	input wire logic drive_ok_in,
	// signals
	input wire logic release_all_in,
	input wire obf_pkg::obf_src_vec_t src_vec_in,
	input wire logic dflt_in,
	input wire logic pri_manip_in,
	input wire logic sec_manip_in,
	// result
	output logic out_out,
	output logic latched_out
);
	obf_pkg::obf_op_t op_q, op_d;
	obf_pkg::obf_sel_t sel_a_q, sel_a_d, sel_b_q, sel_b_d;
	obf_pkg::obf_sel_t sel_c_q, sel_c_d, sel_d_q, sel_d_d;
	logic [3:0] pol_q, pol_d;
	logic fpol_q, fpol_d;
	obf_pkg::obf_latch_t lmode_q, lmode_d;
	logic out_q, out_d, held_q, held_d, hval_q, hval_d;
	logic fn_new, active, bit_a, bit_b, bit_c, bit_d, fn_res, raw, plain;
	logic set_now;
	obf_pkg::obf_latch_t mode;

	// polarity and latch are only writable in a bit function mode
	assign fn_new = fitted_in && drive_ok_in && op_type_in >= `OBF_OP_FN1
		&& op_type_in <= `OBF_OP_FN4;
	assign active = fitted_in && drive_ok_in && op_q >= `OBF_OP_FN1
		&& op_q <= `OBF_OP_FN4;

	always_comb begin
		op_d = op_q;
		sel_a_d = sel_a_q;
		sel_b_d = sel_b_q;
		sel_c_d = sel_c_q;
		sel_d_d = sel_d_q;
		pol_d = pol_q;
		fpol_d = fpol_q;
		lmode_d = lmode_q;
		if (cfg_load_in) begin
			op_d = op_type_in;
			sel_a_d = sel_a_in;
			sel_b_d = sel_b_in;
			sel_c_d = sel_c_in;
			sel_d_d = sel_d_in;
			if (fn_new) begin
				pol_d = src_polarity_in;
				fpol_d = final_polarity_in;
				lmode_d = latch_mode_in;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			op_q <= `OBF_OP_RST;
			sel_a_q <= SEL_A_RST;
			sel_b_q <= `OBF_SRC_OFF;
			sel_c_q <= `OBF_SRC_OFF;
			sel_d_q <= `OBF_SRC_OFF;
			pol_q <= `OBF_SRC_POL_RST;
			fpol_q <= `OBF_FINAL_POL_RST;
			lmode_q <= `OBF_LATCH_RST;
		end else begin
			op_q <= op_d;
			sel_a_q <= sel_a_d;
			sel_b_q <= sel_b_d;
			sel_c_q <= sel_c_d;
			sel_d_q <= sel_d_d;
			pol_q <= pol_d;
			fpol_q <= fpol_d;
			lmode_q <= lmode_d;
		end
	end

	// codes 0 and 1 are constants in src_vec_in
	// digit 0 of the polarity word belongs to source a
	assign bit_a = src_vec_in[sel_a_q] ^ pol_q[0];
	assign bit_b = src_vec_in[sel_b_q] ^ pol_q[1];
	assign bit_c = src_vec_in[sel_c_q] ^ pol_q[2];
	assign bit_d = src_vec_in[sel_d_q] ^ pol_q[3];

	always_comb begin
		case (op_q)
			`OBF_OP_FN1: fn_res = (bit_a & bit_b) | (bit_c & bit_d);
			`OBF_OP_FN2: fn_res = (bit_a | bit_b) & (bit_c | bit_d);
			`OBF_OP_FN3: fn_res = bit_a | bit_b | bit_c | bit_d;
			`OBF_OP_FN4: fn_res = bit_a & bit_b & bit_c & bit_d;
			default: fn_res = 1'b0;
		endcase
	end

	assign raw = fn_res ^ fpol_q;

	// plain path when no bit function is chosen
	always_comb begin
		case (op_q)
			`OBF_OP_DEFAULT: plain = dflt_in;
			`OBF_OP_PRI_MANIP: plain = pri_manip_in;
			`OBF_OP_SEC_MANIP: plain = sec_manip_in;
			default: plain = 1'b0;
		endcase
	end

	assign mode = active ? lmode_q : `OBF_LATCH_NONE;
	// a latch event in the release cycle still sets the latch
	assign set_now = !held_q && ((mode == `OBF_LATCH_ON && raw)
		|| (mode == `OBF_LATCH_OFF && !raw && out_q));

	always_comb begin
		held_d = held_q;
		hval_d = hval_q;
		out_d = raw;
		if (!active) begin
			held_d = 1'b0;
			out_d = fitted_in && drive_ok_in && plain;
		end else if (mode != `OBF_LATCH_ON && mode != `OBF_LATCH_OFF) begin
			held_d = 1'b0;
		end else if (set_now) begin
			held_d = 1'b1;
			hval_d = raw;
		end else if (release_all_in) begin
			held_d = 1'b0;
		end else if (held_q) begin
			out_d = hval_q;
		end
	end

	// power-on clears the latch and leaves output off unlatched
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			out_q <= 1'b0;
			held_q <= 1'b0;
			hval_q <= 1'b0;
		end else begin
			out_q <= out_d;
			held_q <= held_d;
			hval_q <= hval_d;
		end
	end

	assign out_out = out_q;
	assign latched_out = held_q;

	sequence s_fn1_true;
		active && op_q == `OBF_OP_FN1 && lmode_q == `OBF_LATCH_NONE
			&& ((bit_a & bit_b) | (bit_c & bit_d));
	endsequence
	sequence s_off_fall;
		active && lmode_q == `OBF_LATCH_OFF && !held_q && out_q && !raw;
	endsequence

	property p_fn1_out;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		s_fn1_true |=> out_q == !$past(fpol_q);
	endproperty
	a_fn1_out: assert property (p_fn1_out) else $error("fn1 result wrong");
	property p_final_pol;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		active && lmode_q == `OBF_LATCH_NONE && fpol_q
			|=> out_q != $past(fn_res);
	endproperty
	a_final_pol: assert property (p_final_pol) else $error("final pol");
	property p_src_a;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		active && op_q == `OBF_OP_FN4 && lmode_q == `OBF_LATCH_NONE
			&& !fpol_q && pol_q[0] && src_vec_in[sel_a_q] |=> !out_q;
	endproperty
	a_src_a: assert property (p_src_a) else $error("pol a not applied");
	property p_const_off;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		active && op_q == `OBF_OP_FN4 && sel_d_q == `OBF_SRC_OFF
			&& !pol_q[3] && !fpol_q && lmode_q == `OBF_LATCH_NONE
			|=> !out_q;
	endproperty
	a_const_off: assert property (p_const_off) else $error("code 0 not 0");
	property p_on_hold;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		held_q && hval_q && active && lmode_q == `OBF_LATCH_ON
			&& !release_all_in |=> out_q && held_q;
	endproperty
	a_on_hold: assert property (p_on_hold) else $error("on latch lost");
	property p_off_set;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		s_off_fall |=> held_q && !out_q;
	endproperty
	a_off_set: assert property (p_off_set) else $error("off latch unset");
	property p_release;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		release_all_in && !set_now |=> !held_q;
	endproperty
	a_release: assert property (p_release) else $error("release failed");
	property p_mode0_clear;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		lmode_q == `OBF_LATCH_NONE |=> !held_q;
	endproperty
	a_mode0_clear: assert property (p_mode0_clear) else $error("mode 0 held");
	property p_cfg_gate;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		cfg_load_in && !fn_new |=> $stable(pol_q) && $stable(lmode_q)
			&& $stable(fpol_q);
	endproperty
	a_cfg_gate: assert property (p_cfg_gate) else $error("gated write");
	property p_rst_dflt;
		@(posedge clk_sys_in)
		$rose(rst_b_in) |-> pol_q == `OBF_SRC_POL_RST
			&& lmode_q == `OBF_LATCH_RST && !out_q;
	endproperty
	a_rst_dflt: assert property (p_rst_dflt) else $error("reset dflt");
endmodule // obf_channel

/* File: hdl/obf_top.sv */
// output bit function logic for two control and three event outputs.
// assumes all internal signals are synchronous to clk_sys_in.
// Operation
// - four polarity digits, rightmost is source a
// - digit 0 passes, digit 1 inverts source
// - source polarity resets to all zero
// - final polarity 0 direct, 1 inverted
// - latch mode: none, hold on, hold off
// - latch mode resets to none
// - reset, release-all or mode 0 clear latch
// - polarity and latch settings apply only in bit function modes
// - codes 3 to 6 pick and/or function
// - source codes 0 and 1 are constants
`include "obf_defines.svh"
module obf_top (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// release all latches, one-cycle pulse from key or communication
	input wire logic release_all_in,
	// internal sources
	input wire logic [4:0] int_event_in,
	input wire logic primary_manip_output_in,
	input wire logic secondary_manip_output_in,
	input wire logic [1:0] di_in,
	input wire logic [2:0] int_contact_in,
	input wire logic [3:0] comm_di_in,
	input wire logic manual_mode_in,
	input wire logic ready_mode_in,
	input wire logic at_running_in,
	input wire logic sp_ramp_in,
	input wire logic alarm_in,
	input wire logic pv_alarm_in,
	input wire logic mode_key_in,
	// control output 1 settings
	input wire logic ctl_out1_cfg_load_in,
	input wire obf_pkg::obf_op_t ctl_out1_op_type_in,
	input wire obf_pkg::obf_sel_t ctl_out1_sel_a_in,
	input wire obf_pkg::obf_sel_t ctl_out1_sel_b_in,
	input wire obf_pkg::obf_sel_t ctl_out1_sel_c_in,
	input wire obf_pkg::obf_sel_t ctl_out1_sel_d_in,
	input wire logic [3:0] ctl_out1_src_polarity_in,
	input wire logic ctl_out1_final_polarity_in,
	input wire obf_pkg::obf_latch_t ctl_out1_latch_mode_in,
	input wire logic ctl_out1_fitted_in,
	input wire logic ctl_out1_relay_type_in,
	// control output 2 settings
	input wire logic ctl_out2_cfg_load_in,
	input wire obf_pkg::obf_op_t ctl_out2_op_type_in,
	input wire obf_pkg::obf_sel_t ctl_out2_sel_a_in,
	input wire obf_pkg::obf_sel_t ctl_out2_sel_b_in,
	input wire obf_pkg::obf_sel_t ctl_out2_sel_c_in,
	input wire obf_pkg::obf_sel_t ctl_out2_sel_d_in,
	input wire logic [3:0] ctl_out2_src_polarity_in,
	input wire logic ctl_out2_final_polarity_in,
	input wire obf_pkg::obf_latch_t ctl_out2_latch_mode_in,
	input wire logic ctl_out2_fitted_in,
	input wire logic ctl_out2_relay_type_in,
	// event output 1 settings
	input wire logic evt_out1_cfg_load_in,
	input wire obf_pkg::obf_op_t evt_out1_op_type_in,
	input wire obf_pkg::obf_sel_t evt_out1_sel_a_in,
	input wire obf_pkg::obf_sel_t evt_out1_sel_b_in,
	input wire obf_pkg::obf_sel_t evt_out1_sel_c_in,
	input wire obf_pkg::obf_sel_t evt_out1_sel_d_in,
	input wire logic [3:0] evt_out1_src_polarity_in,
	input wire logic evt_out1_final_polarity_in,
	input wire obf_pkg::obf_latch_t evt_out1_latch_mode_in,
	input wire logic evt_out1_fitted_in,
	// event output 2 settings
	input wire logic evt_out2_cfg_load_in,
	input wire obf_pkg::obf_op_t evt_out2_op_type_in,
	input wire obf_pkg::obf_sel_t evt_out2_sel_a_in,
	input wire obf_pkg::obf_sel_t evt_out2_sel_b_in,
	input wire obf_pkg::obf_sel_t evt_out2_sel_c_in,
	input wire obf_pkg::obf_sel_t evt_out2_sel_d_in,
	input wire logic [3:0] evt_out2_src_polarity_in,
	input wire logic evt_out2_final_polarity_in,
	input wire obf_pkg::obf_latch_t evt_out2_latch_mode_in,
	input wire logic evt_out2_fitted_in,
	// event output 3 settings
	input wire logic evt_out3_cfg_load_in,
	input wire obf_pkg::obf_op_t evt_out3_op_type_in,
	input wire obf_pkg::obf_sel_t evt_out3_sel_a_in,
	input wire obf_pkg::obf_sel_t evt_out3_sel_b_in,
	input wire obf_pkg::obf_sel_t evt_out3_sel_c_in,
	input wire obf_pkg::obf_sel_t evt_out3_sel_d_in,
	input wire logic [3:0] evt_out3_src_polarity_in,
	input wire logic evt_out3_final_polarity_in,
	input wire obf_pkg::obf_latch_t evt_out3_latch_mode_in,
	input wire logic evt_out3_fitted_in,
	// outputs to relays and pulse drivers
	output logic ctl_out1_out,
	output logic ctl_out2_out,
	output logic evt_out1_out,
	output logic evt_out2_out,
	output logic evt_out3_out,
	// latch status
	output logic ctl_out1_latched_out,
	output logic ctl_out2_latched_out,
	output logic evt_out1_latched_out,
	output logic evt_out2_latched_out,
	output logic evt_out3_latched_out
);
	obf_pkg::obf_src_vec_t src_vec;

	// own status feeds back from the output register, so no loop forms;
	// an inverted self-reference still toggles every cycle
	always_comb begin
		src_vec = '0;
		src_vec[`OBF_SRC_ON] = 1'b1;
		src_vec[`OBF_SRC_IEV1 +: 5] = int_event_in;
		src_vec[`OBF_SRC_PRI_MANIP] = primary_manip_output_in;
		src_vec[`OBF_SRC_SEC_MANIP] = secondary_manip_output_in;
		src_vec[`OBF_SRC_DI1 +: 2] = di_in;
		src_vec[`OBF_SRC_ICON1 +: 3] = int_contact_in;
		src_vec[`OBF_SRC_CDI1 +: 4] = comm_di_in;
		src_vec[`OBF_SRC_MANUAL] = manual_mode_in;
		src_vec[`OBF_SRC_READY] = ready_mode_in;
		src_vec[`OBF_SRC_AT] = at_running_in;
		src_vec[`OBF_SRC_RAMP] = sp_ramp_in;
		src_vec[`OBF_SRC_ALARM] = alarm_in;
		src_vec[`OBF_SRC_PV_ALARM] = pv_alarm_in;
		src_vec[`OBF_SRC_MODE_KEY] = mode_key_in;
		src_vec[`OBF_SRC_EVT1] = evt_out1_out;
		src_vec[`OBF_SRC_CTL1] = ctl_out1_out;
	end

	obf_channel #(.SEL_A_RST(`OBF_CTL1_SEL_A_RST)) u_ctl1 (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.cfg_load_in(ctl_out1_cfg_load_in),
		.op_type_in(ctl_out1_op_type_in),
		.sel_a_in(ctl_out1_sel_a_in),
		.sel_b_in(ctl_out1_sel_b_in),
		.sel_c_in(ctl_out1_sel_c_in),
		.sel_d_in(ctl_out1_sel_d_in),
		.src_polarity_in(ctl_out1_src_polarity_in),
		.final_polarity_in(ctl_out1_final_polarity_in),
		.latch_mode_in(ctl_out1_latch_mode_in),
		.fitted_in(ctl_out1_fitted_in),
		.drive_ok_in(ctl_out1_relay_type_in),
		.release_all_in(release_all_in),
		.src_vec_in(src_vec),
		.dflt_in(primary_manip_output_in),
		.pri_manip_in(primary_manip_output_in),
		.sec_manip_in(secondary_manip_output_in),
		.out_out(ctl_out1_out),
		.latched_out(ctl_out1_latched_out)
	);

	obf_channel #(.SEL_A_RST(`OBF_CTL2_SEL_A_RST)) u_ctl2 (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.cfg_load_in(ctl_out2_cfg_load_in),
		.op_type_in(ctl_out2_op_type_in),
		.sel_a_in(ctl_out2_sel_a_in),
		.sel_b_in(ctl_out2_sel_b_in),
		.sel_c_in(ctl_out2_sel_c_in),
		.sel_d_in(ctl_out2_sel_d_in),
		.src_polarity_in(ctl_out2_src_polarity_in),
		.final_polarity_in(ctl_out2_final_polarity_in),
		.latch_mode_in(ctl_out2_latch_mode_in),
		.fitted_in(ctl_out2_fitted_in),
		.drive_ok_in(ctl_out2_relay_type_in),
		.release_all_in(release_all_in),
		.src_vec_in(src_vec),
		.dflt_in(secondary_manip_output_in),
		.pri_manip_in(primary_manip_output_in),
		.sec_manip_in(secondary_manip_output_in),
		.out_out(ctl_out2_out),
		.latched_out(ctl_out2_latched_out)
	);

	// event outputs have no drive type restriction
	obf_channel #(.SEL_A_RST(`OBF_EVT1_SEL_A_RST)) u_evt1 (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.cfg_load_in(evt_out1_cfg_load_in),
		.op_type_in(evt_out1_op_type_in),
		.sel_a_in(evt_out1_sel_a_in),
		.sel_b_in(evt_out1_sel_b_in),
		.sel_c_in(evt_out1_sel_c_in),
		.sel_d_in(evt_out1_sel_d_in),
		.src_polarity_in(evt_out1_src_polarity_in),
		.final_polarity_in(evt_out1_final_polarity_in),
		.latch_mode_in(evt_out1_latch_mode_in),
		.fitted_in(evt_out1_fitted_in),
		.drive_ok_in(1'b1),
		.release_all_in(release_all_in),
		.src_vec_in(src_vec),
		.dflt_in(int_event_in[0]),
		.pri_manip_in(primary_manip_output_in),
		.sec_manip_in(secondary_manip_output_in),
		.out_out(evt_out1_out),
		.latched_out(evt_out1_latched_out)
	);

	obf_channel #(.SEL_A_RST(`OBF_EVT2_SEL_A_RST)) u_evt2 (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.cfg_load_in(evt_out2_cfg_load_in),
		.op_type_in(evt_out2_op_type_in),
		.sel_a_in(evt_out2_sel_a_in),
		.sel_b_in(evt_out2_sel_b_in),
		.sel_c_in(evt_out2_sel_c_in),
		.sel_d_in(evt_out2_sel_d_in),
		.src_polarity_in(evt_out2_src_polarity_in),
		.final_polarity_in(evt_out2_final_polarity_in),
		.latch_mode_in(evt_out2_latch_mode_in),
		.fitted_in(evt_out2_fitted_in),
		.drive_ok_in(1'b1),
		.release_all_in(release_all_in),
		.src_vec_in(src_vec),
		.dflt_in(int_event_in[1]),
		.pri_manip_in(primary_manip_output_in),
		.sec_manip_in(secondary_manip_output_in),
		.out_out(evt_out2_out),
		.latched_out(evt_out2_latched_out)
	);

	obf_channel #(.SEL_A_RST(`OBF_EVT3_SEL_A_RST)) u_evt3 (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.cfg_load_in(evt_out3_cfg_load_in),
		.op_type_in(evt_out3_op_type_in),
		.sel_a_in(evt_out3_sel_a_in),
		.sel_b_in(evt_out3_sel_b_in),
		.sel_c_in(evt_out3_sel_c_in),
		.sel_d_in(evt_out3_sel_d_in),
		.src_polarity_in(evt_out3_src_polarity_in),
		.final_polarity_in(evt_out3_final_polarity_in),
		.latch_mode_in(evt_out3_latch_mode_in),
		.fitted_in(evt_out3_fitted_in),
		.drive_ok_in(1'b1),
		.release_all_in(release_all_in),
		.src_vec_in(src_vec),
		.dflt_in(int_event_in[2]),
		.pri_manip_in(primary_manip_output_in),
		.sec_manip_in(secondary_manip_output_in),
		.out_out(evt_out3_out),
		.latched_out(evt_out3_latched_out)
	);
endmodule // obf_top

/* File: test/obf_top_tb.sv */
// self-checking bench for the output bit function block.
// assumes obf_defines.svh on the include path; drives every port directly.
`include "obf_defines.svh"
module obf_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in;
	logic rst_b_in;
	logic rel;
	logic [22:0] sv;
	logic [4:0] ld;
	logic [4:0] fit;
	logic [1:0] rly;
	logic [4:0] o;
	logic [4:0] lt;
	obf_pkg::obf_op_t op [5];
	obf_pkg::obf_sel_t sa [5];
	obf_pkg::obf_sel_t sb [5];
	obf_pkg::obf_sel_t sc [5];
	obf_pkg::obf_sel_t sd [5];
	logic [3:0] pl [5];
	logic fp [5];
	obf_pkg::obf_latch_t lm [5];
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	// source code and its bit in sv
	obf_pkg::obf_sel_t tc [15] = '{6'h30, 6'h06, 6'h0E, 6'h0F, 6'h13, 6'h1C,
		6'h22, 6'h25, 6'h26, 6'h27, 6'h29, 6'h2A, 6'h2C, 6'h2D, 6'h2F};
	int tb [15] = '{0, 4, 5, 6, 8, 11, 12, 15, 16, 17, 18, 19, 20, 21, 22};

	obf_top u_dut (
		.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .release_all_in(rel),
		.int_event_in(sv[4:0]), .primary_manip_output_in(sv[5]),
		.secondary_manip_output_in(sv[6]), .di_in(sv[8:7]),
		.int_contact_in(sv[11:9]), .comm_di_in(sv[15:12]),
		.manual_mode_in(sv[16]), .ready_mode_in(sv[17]),
		.at_running_in(sv[18]), .sp_ramp_in(sv[19]), .alarm_in(sv[20]),
		.pv_alarm_in(sv[21]), .mode_key_in(sv[22]),
		.ctl_out1_cfg_load_in(ld[0]), .ctl_out1_op_type_in(op[0]),
		.ctl_out1_sel_a_in(sa[0]), .ctl_out1_sel_b_in(sb[0]),
		.ctl_out1_sel_c_in(sc[0]), .ctl_out1_sel_d_in(sd[0]),
		.ctl_out1_src_polarity_in(pl[0]), .ctl_out1_final_polarity_in(fp[0]),
		.ctl_out1_latch_mode_in(lm[0]), .ctl_out1_fitted_in(fit[0]),
		.ctl_out1_relay_type_in(rly[0]),
		.ctl_out2_cfg_load_in(ld[1]), .ctl_out2_op_type_in(op[1]),
		.ctl_out2_sel_a_in(sa[1]), .ctl_out2_sel_b_in(sb[1]),
		.ctl_out2_sel_c_in(sc[1]), .ctl_out2_sel_d_in(sd[1]),
		.ctl_out2_src_polarity_in(pl[1]), .ctl_out2_final_polarity_in(fp[1]),
		.ctl_out2_latch_mode_in(lm[1]), .ctl_out2_fitted_in(fit[1]),
		.ctl_out2_relay_type_in(rly[1]),
		.evt_out1_cfg_load_in(ld[2]), .evt_out1_op_type_in(op[2]),
		.evt_out1_sel_a_in(sa[2]), .evt_out1_sel_b_in(sb[2]),
		.evt_out1_sel_c_in(sc[2]), .evt_out1_sel_d_in(sd[2]),
		.evt_out1_src_polarity_in(pl[2]), .evt_out1_final_polarity_in(fp[2]),
		.evt_out1_latch_mode_in(lm[2]), .evt_out1_fitted_in(fit[2]),
		.evt_out2_cfg_load_in(ld[3]), .evt_out2_op_type_in(op[3]),
		.evt_out2_sel_a_in(sa[3]), .evt_out2_sel_b_in(sb[3]),
		.evt_out2_sel_c_in(sc[3]), .evt_out2_sel_d_in(sd[3]),
		.evt_out2_src_polarity_in(pl[3]), .evt_out2_final_polarity_in(fp[3]),
		.evt_out2_latch_mode_in(lm[3]), .evt_out2_fitted_in(fit[3]),
		.evt_out3_cfg_load_in(ld[4]), .evt_out3_op_type_in(op[4]),
		.evt_out3_sel_a_in(sa[4]), .evt_out3_sel_b_in(sb[4]),
		.evt_out3_sel_c_in(sc[4]), .evt_out3_sel_d_in(sd[4]),
		.evt_out3_src_polarity_in(pl[4]), .evt_out3_final_polarity_in(fp[4]),
		.evt_out3_latch_mode_in(lm[4]), .evt_out3_fitted_in(fit[4]),
		.ctl_out1_out(o[0]), .ctl_out2_out(o[1]), .evt_out1_out(o[2]),
		.evt_out2_out(o[3]), .evt_out3_out(o[4]),
		.ctl_out1_latched_out(lt[0]), .ctl_out2_latched_out(lt[1]),
		.evt_out1_latched_out(lt[2]), .evt_out2_latched_out(lt[3]),
		.evt_out3_latched_out(lt[4]));

	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	task automatic results();
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// about 5400 cycles of tests, so a hang is cut well after that
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	task automatic chk(string n, logic [4:0] e, logic [4:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// outputs are sampled on the falling edge, well clear of updates
	task automatic settle(int n);
		repeat (n) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
	endtask

	task automatic cfg(int i, obf_pkg::obf_op_t t, obf_pkg::obf_sel_t a,
		obf_pkg::obf_sel_t b, obf_pkg::obf_sel_t c, obf_pkg::obf_sel_t d,
		logic [3:0] p, logic f, obf_pkg::obf_latch_t l);
		@(posedge clk_sys_in);
		op[i] <= t;
		sa[i] <= a;
		sb[i] <= b;
		sc[i] <= c;
		sd[i] <= d;
		pl[i] <= p;
		fp[i] <= f;
		lm[i] <= l;
		ld[i] <= 1'b1;
		@(posedge clk_sys_in);
		ld[i] <= 1'b0;
		settle(3);
	endtask

	task automatic set_sv(logic [22:0] v);
		@(posedge clk_sys_in);
		sv <= v;
		settle(3);
	endtask

	task automatic pulse_rel();
		@(posedge clk_sys_in);
		rel <= 1'b1;
		@(posedge clk_sys_in);
		rel <= 1'b0;
		settle(3);
	endtask

	task automatic lchk(logic eo, logic el);
		chk("evt1_out", eo, o[2]);
		chk("evt1_latched", el, lt[2]);
	endtask

	function automatic logic fn(int k, logic [3:0] x);
		case (k)
			0: return (x[0] & x[1]) | (x[2] & x[3]);
			1: return (x[0] | x[1]) & (x[2] | x[3]);
			2: return |x;
			default: return &x;
		endcase
	endfunction

	function automatic obf_pkg::obf_sel_t sel(int v, int b);
		return v[b] ? `OBF_SRC_ON : `OBF_SRC_OFF;
	endfunction

	initial begin : main
		logic [3:0] x;
		logic fb;
		rst_b_in = 1'b0;
		rel = 1'b0;
		sv = 23'h00_0025;
		ld = 5'h00;
		fit = 5'h1F;
		rly = 2'h3;
		for (int i = 0; i < 5; i++) begin
			op[i] = `OBF_OP_DEFAULT;
			sa[i] = `OBF_SRC_OFF;
			sb[i] = `OBF_SRC_OFF;
			sc[i] = `OBF_SRC_OFF;
			sd[i] = `OBF_SRC_OFF;
			pl[i] = 4'h0;
			fp[i] = 1'b0;
			lm[i] = `OBF_LATCH_NONE;
		end
		repeat (3) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		settle(2);
		chk("default_out", 5'h15, o);
		chk("default_latched", 5'h00, lt);
		// refused writes leave the reset polarities in force
		@(posedge clk_sys_in);
		fit[4] <= 1'b0;
		rly[1] <= 1'b0;
		cfg(4, `OBF_OP_FN4, 6'h01, 6'h01, 6'h01, 6'h01, 4'h1, 1'b0, 2'h1);
		cfg(1, `OBF_OP_FN4, 6'h01, 6'h01, 6'h01, 6'h01, 4'h0, 1'b1, 2'h1);
		chk("unfitted_out", 5'h00, {o[4], o[1]});
		@(posedge clk_sys_in);
		fit[4] <= 1'b1;
		rly[1] <= 1'b1;
		settle(3);
		chk("reset_polarity", 5'h03, {o[4], o[1]});
		cfg(0, `OBF_OP_SEC_MANIP, 6'h00, 6'h00, 6'h00, 6'h00, 4'hF, 1'b1, 2'h1);
		set_sv(23'h00_0040);
		chk("op_sec", 5'h01, o[0]);
		cfg(0, `OBF_OP_PRI_MANIP, 6'h00, 6'h00, 6'h00, 6'h00, 4'hF, 1'b1, 2'h1);
		chk("op_pri", 5'h00, o[0]);
		for (int k = 0; k < 15; k++) begin
			set_sv(23'h00_0000);
			cfg(0, `OBF_OP_FN1, tc[k], 6'h01, 6'h00, 6'h00, 4'h0, 1'b0, 2'h0);
			chk("src_low", 5'h00, o[0]);
			set_sv(23'h00_0001 << tb[k]);
			chk("src_high", 5'h01, o[0]);
		end
		// own status fed back direct only, so it holds instead of toggling
		set_sv(23'h00_0000);
		cfg(0, `OBF_OP_FN3, `OBF_SRC_CTL1, `OBF_SRC_ICON1, 6'h00, 6'h00, 4'h0, 1'b0, 2'h0);
		set_sv(23'h00_0200);
		set_sv(23'h00_0000);
		chk("self_hold", 5'h01, o[0]);
		cfg(0, 3'h7, 6'h01, 6'h01, 6'h01, 6'h01, 4'h0, 1'b0, 2'h0);
		chk("op_7", 5'h00, o[0]);
		// own-status codes are never paired with an inverting digit
		for (int k = 0; k < 4; k++)
			for (int v = 0; v < 16; v++)
				for (int p = 0; p < 16; p++) begin
					x = 4'(v ^ p);
					fb = 1'(p ^ (v >> 3));
					cfg(3, 3'(`OBF_OP_FN1 + k), sel(v, 0), sel(v, 1), sel(v, 2),
						sel(v, 3), 4'(p), fb, 2'h0);
					chk("func", fn(k, x) ^ fb, o[3]);
				end
		set_sv(23'h00_0000);
		cfg(2, `OBF_OP_FN1, `OBF_SRC_ICON1, 6'h01, 6'h00, 6'h00, 4'h0, 1'b0,
			`OBF_LATCH_ON);
		set_sv(23'h00_0200);
		lchk(1'b1, 1'b1);
		set_sv(23'h00_0000);
		lchk(1'b1, 1'b1);
		pulse_rel();
		lchk(1'b0, 1'b0);
		set_sv(23'h00_0200);
		set_sv(23'h00_0000);
		cfg(2, `OBF_OP_FN1, `OBF_SRC_ICON1, 6'h01, 6'h00, 6'h00, 4'h0, 1'b0,
			`OBF_LATCH_NONE);
		lchk(1'b0, 1'b0);
		cfg(2, `OBF_OP_FN1, `OBF_SRC_ICON1, 6'h01, 6'h00, 6'h00, 4'h0, 1'b0,
			`OBF_LATCH_OFF);
		lchk(1'b0, 1'b0);
		set_sv(23'h00_0200);
		lchk(1'b1, 1'b0);
		set_sv(23'h00_0000);
		lchk(1'b0, 1'b1);
		set_sv(23'h00_0200);
		lchk(1'b0, 1'b1);
		pulse_rel();
		lchk(1'b1, 1'b0);
		cfg(2, `OBF_OP_FN1, `OBF_SRC_ICON1, 6'h01, 6'h00, 6'h00, 4'h0, 1'b0,
			`OBF_LATCH_ON);
		lchk(1'b1, 1'b1);
		// reset in mid-run drops the latch and all settings
		@(posedge clk_sys_in);
		rst_b_in <= 1'b0;
		@(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		settle(3);
		lchk(1'b0, 1'b0);
		results();
	end
endmodule // obf_top_tb
